// ===== core/rsq_pkg.sv
// Shared constants for the ramp segment sequencer
package rsq_pkg;

  // Structure
  localparam int SEG_COUNT  = 8;
  localparam int SEG_IDX_W  = 3;
  localparam int STEP_W     = 30;
  localparam int ACC_W      = 33;
  localparam int DUR_W      = 16;
  localparam int DUR_CNT_W  = 17;
  localparam int REPEAT_W   = 13;
  localparam int SEG_CTRL_W = 26;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_LIM_LO_L = 8'h08;
  localparam logic [7:0] ADDR_LIM_LO_H = 8'h0c;
  localparam logic [7:0] ADDR_LIM_HI_L = 8'h10;
  localparam logic [7:0] ADDR_LIM_HI_H = 8'h14;
  localparam logic [7:0] ADDR_ACC_L    = 8'h18;
  localparam logic [7:0] ADDR_ACC_H    = 8'h1c;
  // Segment words: base + 8*index, step word then control word
  localparam logic [1:0] SEG_PAGE      = 2'h1;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;

  // Status register fields
  localparam int STAT_SEG_LSB = 0;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_REP_LSB = 4;

  // Segment control word fields
  localparam int SEG_DUR_LSB  = 0;
  localparam int SEG_HALF_BIT = 16;
  localparam int SEG_FAST_BIT = 17;
  localparam int SEG_MARK_LSB = 18;
  localparam int SEG_CLR_BIT  = 20;
  localparam int SEG_ADV_LSB  = 21;
  localparam int SEG_SUCC_LSB = 23;

  // Reset values
  localparam logic [STEP_W-1:0]     SEG_STEP_RST  = 30'h0000_0000;
  localparam logic [SEG_CTRL_W-1:0] SEG_CTRL_RST  = 26'h000_0000;
  localparam logic [ACC_W-1:0]      LIM_LO_RST    = 33'h0_0000_0000;
  localparam logic [ACC_W-1:0]      LIM_HI_RST    = 33'h0_ffff_ffff;

  // Timing: a zero duration field stands for the longest run
  localparam logic [DUR_CNT_W-1:0]  DUR_MAX_TICKS = 17'h1_0000;

  // Advance conditions
  typedef enum logic [1:0] {
    ADV_DURATION,
    ADV_EVENT_A,
    ADV_EVENT_B,
    ADV_EVENT_C
  } rsq_adv_t;

  // Sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } rsq_state_t;

endpackage

// ===== core/rsq_seg_regs.sv
`timescale 1ns/10ps
// One segment's step and control words
module rsq_seg_regs import rsq_pkg::*; (
  // System
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // Write strobes and data
  input  wire logic                  wr_step_i,
  input  wire logic                  wr_ctrl_i,
  input  wire logic [31:0]           wdata_i,
  // Stored settings
  output logic      [STEP_W-1:0]     step_o,
  output logic      [SEG_CTRL_W-1:0] ctrl_o
);

  // Signed step, kept in the low bits of its word
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      step_o <= SEG_STEP_RST;
    end else if (wr_step_i) begin
      step_o <= wdata_i[STEP_W-1:0];
    end
  end

  // Duration, options, markers, advance source and successor
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_o <= SEG_CTRL_RST;
    end else if (wr_ctrl_i) begin
      ctrl_o <= wdata_i[SEG_CTRL_W-1:0];
    end
  end

endmodule // rsq_seg_regs

// ===== core/rsq_sequencer.sv
`timescale 1ns/10ps
// What this block does
// R1: Eight segments, each with own settings
// R2: Fast-settle bit drives fast lock output
// R3: Half-rate makes each tick two cycles
// R4: Duration counts ticks, one to 65536
// R5: Marker bits drive two marker outputs
// R6: Accumulator-clear zeroes accumulator on entry
// R7: Software sets clear on first segment
// R8: Advance source: duration or events A-C
// R9: Ending segment jumps to its successor
// R10: Each tick adds sign-extended step
// R11: Repeat counter clears on enable rise
// R12: Accumulator clamped between lower/upper limits
module rsq_sequencer import rsq_pkg::*; (
  // System
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Advance events
  input  wire logic             event_source_a_i,
  input  wire logic             event_source_b_i,
  input  wire logic             event_source_c_i,
  // Ramp outputs
  output logic      [ACC_W-1:0] ramp_accum_o,
  output logic                  fast_settle_o,
  output logic                  marker_out_a_o,
  output logic                  marker_out_b_o,
  output logic      [2:0]       active_segment_o,
  output logic                  ramp_running_o
);

  logic [STEP_W-1:0]     seg_step [SEG_COUNT];
  logic [SEG_CTRL_W-1:0] seg_ctrl [SEG_COUNT];
  logic                  ramp_enable;
  logic                  enable_seen;
  logic [ACC_W-1:0]      limit_low;
  logic [ACC_W-1:0]      limit_high;
  logic [REPEAT_W-1:0]   repeat_cnt;
  rsq_state_t            state;
  logic [SEG_IDX_W-1:0]  seg;
  logic [DUR_CNT_W-1:0]  dur_cnt;
  logic                  phase;
  logic [ACC_W-1:0]      accum;
  logic                  apb_access;
  logic                  wr_commit;
  logic                  seg_hit;
  logic [SEG_IDX_W-1:0]  wr_idx;
  logic [31:0]           rd_data;
  logic                  rd_ok;

  // APB handshake: answer one cycle into the access phase
  assign apb_access = psel_i & penable_i & ~pready_o;
  assign wr_commit  = psel_i & penable_i & pready_o & pwrite_i;
  assign seg_hit    = (paddr_i[7:6] == SEG_PAGE) && (paddr_i[1:0] == 2'h0);
  assign wr_idx     = paddr_i[5:3];

  // Segment banks, one per index
  for (genvar g = 0; g < SEG_COUNT; g++) begin : g_seg
    // R1: independent segment settings
    rsq_seg_regs u_regs (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .wr_step_i (wr_commit && seg_hit && wr_idx == SEG_IDX_W'(g) && !paddr_i[2]),
      .wr_ctrl_i (wr_commit && seg_hit && wr_idx == SEG_IDX_W'(g) && paddr_i[2]),
      .wdata_i   (pwdata_i),
      .step_o    (seg_step[g]),
      .ctrl_o    (seg_ctrl[g])
    );
  end

  // Read decode; unmapped addresses read zero with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (seg_hit) begin
      if (paddr_i[2]) begin
        rd_data[SEG_CTRL_W-1:0] = seg_ctrl[wr_idx];
      end else begin
        rd_data[STEP_W-1:0] = seg_step[wr_idx];
      end
    end else begin
      unique case (paddr_i)
        ADDR_CTRL:     rd_data[CTRL_EN_BIT] = ramp_enable;
        ADDR_STATUS: begin
          rd_data[STAT_SEG_LSB +: SEG_IDX_W] = seg;
          rd_data[STAT_RUN_BIT]              = (state == ST_RUN);
          rd_data[STAT_REP_LSB +: REPEAT_W]  = repeat_cnt;
        end
        ADDR_LIM_LO_L: rd_data = limit_low[31:0];
        ADDR_LIM_LO_H: rd_data[0] = limit_low[ACC_W-1];
        ADDR_LIM_HI_L: rd_data = limit_high[31:0];
        ADDR_LIM_HI_H: rd_data[0] = limit_high[ACC_W-1];
        ADDR_ACC_L:    rd_data = accum[31:0];
        ADDR_ACC_H:    rd_data[0] = accum[ACC_W-1];
        default:       rd_ok = 1'b0;
      endcase
    end
  end

  // Bus answer flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= apb_access;
      pslverr_o <= apb_access & ~rd_ok;
      prdata_o  <= (apb_access && !pwrite_i) ? rd_data : 32'h0000_0000;
    end
  end

  // Global control and limit registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ramp_enable <= 1'b0;
      limit_low   <= LIM_LO_RST;
      limit_high  <= LIM_HI_RST;
    end else if (wr_commit && !seg_hit) begin
      unique case (paddr_i)
        ADDR_CTRL:     ramp_enable <= pwdata_i[CTRL_EN_BIT];
        ADDR_LIM_LO_L: limit_low[31:0] <= pwdata_i;
        ADDR_LIM_LO_H: limit_low[ACC_W-1] <= pwdata_i[0];
        ADDR_LIM_HI_L: limit_high[31:0] <= pwdata_i;
        ADDR_LIM_HI_H: limit_high[ACC_W-1] <= pwdata_i[0];
        default: ;
      endcase
    end
  end

  // Current and target segment fields
  logic [SEG_CTRL_W-1:0]   cur_ctrl;
  logic [SEG_CTRL_W-1:0]   tgt_ctrl;
  logic [SEG_IDX_W-1:0]    target_seg;
  logic [DUR_W-1:0]        tgt_dur;
  logic [DUR_CNT_W-1:0]    tgt_dur_load;
  rsq_adv_t                cur_adv;
  logic                    cur_half;
  logic                    running;
  logic                    en_rise;
  logic                    tick;
  logic                    adv_event;
  logic                    seg_end;
  logic                    seg_start;
  logic signed [ACC_W:0]   sum_wide;
  logic [ACC_W-1:0]        next_accum;

  assign cur_ctrl   = seg_ctrl[seg];
  assign cur_adv    = rsq_adv_t'(cur_ctrl[SEG_ADV_LSB +: 2]);
  assign cur_half   = cur_ctrl[SEG_HALF_BIT];
  assign running    = (state == ST_RUN) && ramp_enable;
  assign en_rise    = ramp_enable && !enable_seen;
  // R9: successor of the ending segment
  assign target_seg = en_rise ? '0 : cur_ctrl[SEG_SUCC_LSB +: SEG_IDX_W];
  assign tgt_ctrl   = seg_ctrl[target_seg];
  assign tgt_dur    = tgt_ctrl[SEG_DUR_LSB +: DUR_W];
  // R4: zero field means the longest run
  assign tgt_dur_load = (tgt_dur == '0) ? DUR_MAX_TICKS : {1'b0, tgt_dur};
  // R3: slow segments tick on every second cycle
  assign tick       = running && (!cur_half || phase);

  // R8: advance source select
  always_comb begin
    unique case (cur_adv)
      ADV_DURATION: adv_event = tick && (dur_cnt == DUR_CNT_W'(1));
      ADV_EVENT_A:  adv_event = event_source_a_i;
      ADV_EVENT_B:  adv_event = event_source_b_i;
      ADV_EVENT_C:  adv_event = event_source_c_i;
    endcase
  end
  assign seg_end   = running && adv_event;
  assign seg_start = ramp_enable && (en_rise || seg_end);

  // R10: sign-extended step added each tick
  assign sum_wide = $signed({accum[ACC_W-1], accum}) +
                    $signed({{(ACC_W+1-STEP_W){seg_step[seg][STEP_W-1]}}, seg_step[seg]});

  // R12: clamp against the limits, both signed
  always_comb begin
    if (sum_wide < $signed({limit_low[ACC_W-1], limit_low})) begin
      next_accum = limit_low;
    end else if (sum_wide > $signed({limit_high[ACC_W-1], limit_high})) begin
      next_accum = limit_high;
    end else begin
      next_accum = sum_wide[ACC_W-1:0];
    end
  end

  // Enable edge detector
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enable_seen <= 1'b0;
    end else begin
      enable_seen <= ramp_enable;
    end
  end

  // Segment walk, tick phase and duration count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state   <= ST_IDLE;
      seg     <= '0;
      dur_cnt <= '0;
      phase   <= 1'b0;
    end else if (!ramp_enable) begin
      state <= ST_IDLE;
      phase <= 1'b0;
    end else if (seg_start) begin
      // R9: enter the next segment fresh
      state   <= ST_RUN;
      seg     <= target_seg;
      dur_cnt <= tgt_dur_load;
      phase   <= 1'b0;
    end else if (running) begin
      // R3: phase toggles only in slow segments
      phase <= cur_half ? ~phase : 1'b0;
      // R4: count down ticks, held at one under event advance
      if (tick && dur_cnt != DUR_CNT_W'(1)) begin
        dur_cnt <= dur_cnt - DUR_CNT_W'(1);
      end
    end
  end

  // Ramp accumulator; a clear on entry beats the last tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      accum <= '0;
    end else if (seg_start && tgt_ctrl[SEG_CLR_BIT]) begin
      // R6: clear creep on segment entry
      accum <= '0;
    end else if (tick) begin
      // R10: apply the clamped sum
      accum <= next_accum;
    end
  end

  // Repeat counter counts segment transitions
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      repeat_cnt <= '0;
    end else if (en_rise) begin
      // R11: clear on enable rise
      repeat_cnt <= '0;
    end else if (seg_end) begin
      repeat_cnt <= repeat_cnt + REPEAT_W'(1);
    end
  end

  // Registered outputs; markers and fast settle lag the segment by one cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fast_settle_o  <= 1'b0;
      marker_out_a_o <= 1'b0;
      marker_out_b_o <= 1'b0;
    end else begin
      // R2: fast lock while the segment runs
      fast_settle_o  <= running && cur_ctrl[SEG_FAST_BIT];
      // R5: marker bits onto the pins
      marker_out_a_o <= running && cur_ctrl[SEG_MARK_LSB];
      marker_out_b_o <= running && cur_ctrl[SEG_MARK_LSB+1];
    end
  end

  assign ramp_accum_o     = accum;
  assign active_segment_o = seg;
  assign ramp_running_o   = (state == ST_RUN);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_succ;
    seg_end |=> seg == $past(cur_ctrl[SEG_SUCC_LSB +: SEG_IDX_W]);
  endproperty
  a_succ: assert property (p_succ) else $error("successor not taken"); // R9

  property p_fast;
    running |=> fast_settle_o == $past(cur_ctrl[SEG_FAST_BIT]);
  endproperty
  a_fast: assert property (p_fast) else $error("fast settle mismatch"); // R2

  property p_half;
    tick && cur_half && !seg_start |=> !tick;
  endproperty
  a_half: assert property (p_half) else $error("half rate tick too soon"); // R3

  property p_one_tick;
    seg_start && tgt_dur_load == DUR_CNT_W'(1) && tgt_ctrl[SEG_ADV_LSB +: 2] == 2'h0
      && !tgt_ctrl[SEG_HALF_BIT] |=> seg_end || !ramp_enable;
  endproperty
  a_one_tick: assert property (p_one_tick) else $error("one tick segment overran"); // R4

  property p_marker;
    running |=> {marker_out_b_o, marker_out_a_o} == $past(cur_ctrl[SEG_MARK_LSB +: 2]);
  endproperty
  a_marker: assert property (p_marker) else $error("marker mismatch"); // R5

  property p_clear;
    seg_start && tgt_ctrl[SEG_CLR_BIT] |=> accum == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("accumulator not cleared"); // R6

  property p_hold;
    running && cur_adv != ADV_DURATION && !adv_event |=> $stable(seg);
  endproperty
  a_hold: assert property (p_hold) else $error("segment ended without event"); // R8

  property p_step;
    tick && !seg_start && sum_wide[ACC_W-1:0] == next_accum |=> accum == $past(sum_wide[ACC_W-1:0]);
  endproperty
  a_step: assert property (p_step) else $error("step not added"); // R10

  property p_repeat;
    en_rise |=> repeat_cnt == '0;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat count not cleared"); // R11

  property p_clamp;
    tick && !seg_start && $signed(limit_low) <= $signed(limit_high)
      |=> $signed(accum) >= $signed($past(limit_low)) && $signed(accum) <= $signed($past(limit_high));
  endproperty
  a_clamp: assert property (p_clamp) else $error("accumulator outside limits"); // R12

endmodule // rsq_sequencer

// ===== testbench/rsq_mod_model.sv
`timescale 1ns/10ps
// Fractional modulator fed by the ramp value
module rsq_mod_model import rsq_pkg::*; (
  // System
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Ramp value from the sequencer
  input  wire logic [ACC_W-1:0] ramp_i,
  // Observed activity
  output logic      [31:0]      ticks_o,
  output logic      [ACC_W-1:0] phase_o
);
  logic [ACC_W-1:0] last;

  // Phase integrates the ramp; each change of the ramp counts as a tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      last    <= '0;
      ticks_o <= '0;
      phase_o <= '0;
    end else begin
      last    <= ramp_i;
      phase_o <= phase_o + ramp_i;
      if (ramp_i !== last) ticks_o <= ticks_o + 32'h1;
    end
  end
endmodule // rsq_mod_model

// ===== testbench/test_ramp_segment_sequencer.sv
`timescale 1ns/10ps
module test_ramp_segment_sequencer import rsq_pkg::*;;
  logic             clk_i;
  logic             srst_i;
  logic             psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd, n0;
  logic [2:0]       ev, seg;
  logic [ACC_W-1:0] acc, a0, phase;
  logic             fast, mka, mkb, run, er;
  logic [31:0]      ticks;
  int               n_fail = 0;
  int               comparisons = 0;

  // Mismatches are reported and counted at once
  `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h, expected %h", $time, a, e); end end

  rsq_sequencer dut_u (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .event_source_a_i(ev[0]), .event_source_b_i(ev[1]), .event_source_c_i(ev[2]),
    .ramp_accum_o(acc), .fast_settle_o(fast), .marker_out_a_o(mka), .marker_out_b_o(mkb),
    .active_segment_o(seg), .ramp_running_o(run));

  rsq_mod_model mod_u (.clk_i(clk_i), .srst_i(srst_i), .ramp_i(acc), .ticks_o(ticks), .phase_o(phase));

  // 50 MHz clock
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Sampled at the rising edge, before the slave's flops move on
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Bounded wait for a segment index
  task automatic waitseg(input logic [2:0] s);
    int k;
    k = 0;
    while (seg !== s && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 300) n_fail++;
  endtask

  // One-cycle event pulse on source i
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev    <= 3'h0;
  endtask

  // Control word: duration, half, fast, markers, clear, advance, successor
  function automatic logic [31:0] ctl(input logic [15:0] du, input logic h, f, input logic [1:0] m,
                                      input logic c, input logic [1:0] ad, input logic [2:0] su);
    return {6'h0, su, ad, c, m, f, h, du};
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    srst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    // Reset values, segment independence, unmapped address
    apb(0, ADDR_LIM_HI_L, 0); `CHK(rd, 32'hffff_ffff)
    apb(1, 8'h7c, 32'hffff_ffff);
    apb(0, 8'h7c, 0); `CHK(rd, 32'h03ff_ffff)
    apb(0, 8'h74, 0); `CHK(rd, 32'h0)
    apb(0, 8'h20, 0); `CHK({er, rd}, {1'b1, 32'h0})
    // Seg0 clears the accumulator at pattern start
    // clear on first
    apb(1, 8'h44, ctl(16'h3, 1'b0, 1'b1, 2'h1, 1'b1, 2'h0, 3'h1));
    apb(1, 8'h40, 32'h5);
    apb(1, 8'h4c, ctl(16'h2, 1'b1, 1'b0, 2'h2, 1'b0, 2'h1, 3'h0));
    apb(1, 8'h48, 32'h3fff_fffe);
    apb(1, ADDR_CTRL, 32'h1);
    waitseg(3'h1); `CHK(acc, 33'd15)
    a0 = acc;
    n0 = ticks;
    wcyc(1); `CHK({mka, mkb, fast}, 3'b010)
    wcyc(7); `CHK({ticks - n0, 33'(a0 - acc)}, {32'd4, 33'd8})
    wcyc(20); `CHK(acc, 33'd0)
    pulse(1);
    wcyc(3); `CHK(seg, 3'h1)
    pulse(0);
    waitseg(3'h0); `CHK(acc, 33'd0)
    wcyc(1); `CHK(acc, 33'd5)
    // Restart with upper limit and an event-ended first segment
    apb(1, ADDR_CTRL, 32'h0);
    apb(1, ADDR_LIM_HI_L, 32'h7);
    apb(1, 8'h44, ctl(16'h3, 1'b0, 1'b1, 2'h1, 1'b1, 2'h3, 3'h2));
    // One-tick segment between the event end and segment one
    apb(1, 8'h54, ctl(16'h1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 3'h1));
    apb(1, ADDR_CTRL, 32'h1);
    // Accumulator held a nonzero value while idle, so the clear shows
    wcyc(2); `CHK(acc, 33'd0)
    apb(0, ADDR_STATUS, 0); `CHK(rd, 32'h8)
    wcyc(1); `CHK({acc, mka, mkb, fast}, {33'd7, 3'b101})
    pulse(2);
    waitseg(3'h2);
    wcyc(1); `CHK({seg, run}, {3'h1, 1'b1})
    apb(1, ADDR_CTRL, 32'h0);
    wcyc(2); `CHK(run, 1'b0)
    conclude();
  end

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #200us;
    n_fail++;
    conclude();
  end
endmodule // test_ramp_segment_sequencer
